/* hdl/cfg_loader_pkg.sv */
// Summary of operation
// - with pin addressing the two-wire host address is 10101 followed by the two select pin levels.
// - bit 4 of the interface byte at nonvolatile address 21h picks pin or stored two-wire address.
// - bit 4 clear (default) uses the pin address, set uses the stored address byte.
// - bit 7 clear selects high-speed, set (default) selects high-speed-plus two-wire mode.
// - bit 3 set (default) turns boundary scan on, clear turns it off.
// - host field 000b UART, 001b two-wire, 010b SPI, 011b low-voltage two-wire, 1xxb from pins.
// - the secure-module port address always comes from the stored byte.
// - a protocol setting is 16 transmit bytes and 8 receive bytes copied into those groups.
// - only read/write or dynamic register bits are updated by a copy.
// - the stored reset image is the configuration applied after startup.
// - the source addresses of the copy depend on the chosen protocol, at a fixed 24-byte stride from 1C00h.
// - a protocol load command copies a chosen stored protocol into the registers.
// - the reset image maps byte by byte onto registers in order, starting at address 40h.
// - the stored transmit CRC preset at 26h is read at startup and passed out unchanged on o_transmit_crc_init.
// - at startup the reset area is copied into the registers before normal operation.
package cfg_loader_pkg;
	localparam logic [12:0] NV_TWI_ADDR      = 13'h0020;
	localparam logic [12:0] NV_IFACE_CFG     = 13'h0021;
	localparam logic [12:0] NV_SAM_ADDR      = 13'h0022;
	localparam logic [12:0] NV_TX_CRC_INIT   = 13'h0026;
	localparam logic [12:0] NV_RESET_IMAGE   = 13'h0040;
	localparam logic [12:0] NV_PROTO_BASE    = 13'h1C00;
	localparam int          IMAGE_LEN        = 96;
	localparam int          PROTO_TX_LEN     = 16;
	localparam int          PROTO_RX_LEN     = 8;
	localparam logic [7:0]  REG_TX_BASE      = 8'h28;
	localparam logic [7:0]  REG_RX_BASE      = 8'h58;
	localparam int          CFG_SPEED_BIT    = 7;
	localparam int          CFG_ADDRSRC_BIT  = 4;
	localparam int          CFG_SCAN_BIT     = 3;
	localparam logic [4:0]  PIN_ADDR_PREFIX  = 5'h15;
	localparam logic [7:0]  IFACE_CFG_RESET  = 8'h88;
	// software register map of this block
	localparam logic [7:0]  RA_CMD           = 8'h00;
	localparam logic [7:0]  RA_STATUS        = 8'h01;
	localparam logic [7:0]  RA_IFACE_CFG     = 8'h02;
	localparam logic [7:0]  RA_TWI_ADDR      = 8'h03;
	localparam logic [7:0]  RA_SAM_ADDR      = 8'h04;
	localparam logic [7:0]  RA_TX_CRC        = 8'h05;
	localparam logic [7:0]  RA_PROTO_TX      = 8'h06;
	localparam logic [7:0]  RA_PROTO_RX      = 8'h07;
	localparam logic [7:0]  RA_IMAGE_BASE    = 8'h40;
	localparam logic [7:0]  RA_IMAGE_LAST    = 8'h9F;
	typedef enum logic [1:0] {
		HOST_UART, HOST_TWI, HOST_SPI, HOST_TWI_LV
	} host_sel_t;
endpackage

/* hdl/cfg_image_ram.sv */
`timescale 1ns/1ps
`default_nettype none
// register image store: one write port, registered read
module cfg_image_ram (
	// clock
	input  wire logic       i_mclk,
	// write port
	input  wire logic       i_we,
	input  wire logic [6:0] i_waddr,
	input  wire logic [7:0] i_wdata,
	// read port
	input  wire logic [6:0] i_raddr,
	output logic      [7:0] o_rdata
);
	logic [7:0] mem [0:127];

	always_ff @(posedge i_mclk) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
		o_rdata <= mem[i_raddr];
	end
endmodule // cfg_image_ram
`default_nettype wire

/* hdl/eeprom_startup_config_loader.sv */
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module eeprom_startup_config_loader (
	// clock and reset
	input  wire logic        i_mclk,
	input  wire logic        i_srst,
	// interface select pins
	input  wire logic        i_iface_sel_pin_a,
	input  wire logic        i_iface_sel_pin_b,
	input  wire logic        i_iface_sel_pin_c,
	// nonvolatile memory read port, data one cycle after request
	output logic             o_nv_rd,
	output logic      [12:0] o_nv_addr,
	input  wire logic [7:0]  i_nv_rdata,
	// software register port
	input  wire logic [7:0]  i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [7:0]  o_rdata,
	// applied configuration
	output logic             o_ready,
	output logic      [6:0]  o_twi_addr,
	output logic      [6:0]  o_sam_addr,
	output cfg_loader_pkg::host_sel_t o_host_sel,
	output logic             o_twi_speed_variant,
	output logic             o_low_voltage_twowire,
	output logic             o_scan_en,
	output logic      [7:0]  o_transmit_crc_init
);
	import cfg_loader_pkg::*;

	typedef enum logic [2:0] {
		ST_CFG, ST_IMAGE, ST_IDLE, ST_PROTO
	} state_t;

	state_t      state;
	logic [6:0]  idx;
	logic        pend;
	logic [6:0]  pend_idx;
	logic [1:0]  hdr_cnt;
	// header reads tracked apart from idx, so header bytes never land in the image
	logic        hdr_req;
	logic [1:0]  hdr_sel;
	logic        pend_hdr;
	logic [1:0]  pend_hsel;
	logic [7:0]  iface_cfg;
	logic [7:0]  twi_stored;
	logic [4:0]  proto_sel;
	logic        proto_rx;
	logic        busy_err;
	logic        ram_we;
	logic [6:0]  ram_waddr;
	logic [7:0]  ram_wdata;
	logic [6:0]  ram_raddr;
	logic [7:0]  ram_rdata;
	logic        rd_img;
	logic [7:0]  rd_reg;
	logic [7:0]  rw_mask [0:IMAGE_LEN-1];

	// register bits writable by copy; read-only status bytes stay untouched
	function automatic logic [7:0] copy_mask(input logic [6:0] i);
		case (i)
			7'h0B, 7'h0D, 7'h42, 7'h43, 7'h49: copy_mask = 8'h00;
			default:                          copy_mask = 8'hFF;
		endcase
	endfunction

	genvar g;
	generate
		for (g = 0; g < IMAGE_LEN; g++) begin : g_mask
			assign rw_mask[g] = copy_mask(7'(g));
		end
	endgenerate

	function automatic logic in_image(input logic [7:0] a);
		in_image = (a >= RA_IMAGE_BASE) && (a <= RA_IMAGE_LAST);
	endfunction

	// protocol source: tx bytes then rx bytes, per-protocol 24-byte stride
	function automatic logic [12:0] proto_src(input logic [4:0] p, input logic [6:0] i);
		proto_src = NV_PROTO_BASE + 13'(p) * 13'd24 + 13'(i);
	endfunction

	// sequencer
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			state    <= ST_CFG;
			idx      <= '0;
			hdr_cnt  <= '0;
			pend     <= 1'b0;
			pend_idx <= '0;
			o_nv_rd  <= 1'b0;
			o_nv_addr <= '0;
			hdr_req   <= 1'b0;
			hdr_sel   <= '0;
			pend_hdr  <= 1'b0;
			pend_hsel <= '0;
		end else begin
			pend     <= o_nv_rd;
			pend_idx <= idx;
			o_nv_rd  <= 1'b0;
			hdr_req   <= 1'b0;
			hdr_sel   <= hdr_cnt;
			pend_hdr  <= hdr_req;
			pend_hsel <= hdr_sel;
			unique case (state)
				ST_CFG: begin
					o_nv_rd <= 1'b1;
					hdr_req <= 1'b1;
					unique case (hdr_cnt)
						2'd0: o_nv_addr <= NV_TWI_ADDR;
						2'd1: o_nv_addr <= NV_IFACE_CFG;
						2'd2: o_nv_addr <= NV_SAM_ADDR;
						default: o_nv_addr <= NV_TX_CRC_INIT;
					endcase
					idx     <= {5'd0, hdr_cnt};
					hdr_cnt <= hdr_cnt + 2'd1;
					if (hdr_cnt == 2'd3) begin
						state <= ST_IMAGE;
						idx   <= 7'h7F;
					end
				end
				ST_IMAGE: begin
					// image bytes in register order from 40h
					if (idx == 7'h7F || idx < 7'(IMAGE_LEN - 1)) begin
						o_nv_rd   <= 1'b1;
						idx       <= idx + 7'd1;
						o_nv_addr <= NV_RESET_IMAGE + 13'(7'(idx + 7'd1));
					end else if (!pend) begin
						state <= ST_IDLE;
					end
				end
				ST_IDLE: begin
					if (i_wr && i_addr == RA_CMD && i_wdata[7]) begin
						state     <= ST_PROTO;
						o_nv_rd   <= 1'b1;
						idx       <= '0;
						o_nv_addr <= proto_src(i_wdata[4:0], 7'd0);
					end
				end
				ST_PROTO: begin
					if (idx < 7'(PROTO_TX_LEN + PROTO_RX_LEN - 1)) begin
						o_nv_rd   <= 1'b1;
						idx       <= idx + 7'd1;
						o_nv_addr <= proto_src(proto_sel, 7'(idx + 7'd1));
					end else if (!pend) begin
						state <= ST_IDLE;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			proto_sel <= '0;
			busy_err  <= 1'b0;
		end else if (i_wr && i_addr == RA_CMD && i_wdata[7]) begin
			// a command during a copy is dropped and flagged
			if (state == ST_IDLE) begin
				proto_sel <= i_wdata[4:0];
			end else begin
				busy_err <= 1'b1;
			end
		end else if (i_wr && i_addr == RA_STATUS && i_wdata[1]) begin
			busy_err <= 1'b0;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			proto_rx <= 1'b0;
		end else begin
			proto_rx <= pend && state == ST_PROTO;
		end
	end

	// image writes: nv returns, or software writes to image bytes
	always_comb begin
		ram_we    = 1'b0;
		ram_waddr = '0;
		ram_wdata = '0;
		if (pend && !pend_hdr && state == ST_IMAGE) begin
			ram_we    = rw_mask[pend_idx] != 8'h00;
			ram_waddr = pend_idx;
			ram_wdata = i_nv_rdata & rw_mask[pend_idx];
		end else if (pend && state == ST_PROTO) begin
			ram_we    = 1'b1;
			ram_waddr = (pend_idx < 7'(PROTO_TX_LEN))
				? 7'(REG_TX_BASE + 8'(pend_idx))
				: 7'(REG_RX_BASE + 8'(pend_idx) - 8'(PROTO_TX_LEN));
			ram_wdata = i_nv_rdata;
		end else if (i_wr && in_image(i_addr) && state == ST_IDLE) begin
			ram_we    = 1'b1;
			ram_waddr = 7'(i_addr - RA_IMAGE_BASE);
			ram_wdata = i_wdata;
		end
	end

	assign ram_raddr = 7'(i_addr - RA_IMAGE_BASE);

	cfg_image_ram u_ram (
		.i_mclk  (i_mclk),
		.i_we    (ram_we),
		.i_waddr (ram_waddr),
		.i_wdata (ram_wdata),
		.i_raddr (ram_raddr),
		.o_rdata (ram_rdata)
	);

	// header bytes captured once at startup
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			iface_cfg           <= IFACE_CFG_RESET;
			twi_stored          <= '0;
			o_sam_addr          <= '0;
			o_transmit_crc_init <= '0;
		end else if (pend_hdr) begin
			unique case (pend_hsel)
				2'd0: twi_stored          <= i_nv_rdata;
				2'd1: iface_cfg           <= i_nv_rdata;
				2'd2: o_sam_addr          <= i_nv_rdata[6:0];
				default: o_transmit_crc_init <= i_nv_rdata;
			endcase
		end
	end

	// applied choice frozen when the startup copy finishes
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_ready               <= 1'b0;
			o_twi_addr            <= '0;
			o_host_sel            <= HOST_UART;
			o_twi_speed_variant   <= 1'b1;
			o_low_voltage_twowire <= 1'b0;
			o_scan_en             <= 1'b1;
		end else if (!o_ready && state == ST_IDLE) begin
			o_ready <= 1'b1;
			o_twi_addr <= iface_cfg[CFG_ADDRSRC_BIT]
				? twi_stored[6:0]
				: {PIN_ADDR_PREFIX, i_iface_sel_pin_c, i_iface_sel_pin_a};
			o_twi_speed_variant <= iface_cfg[CFG_SPEED_BIT];
			o_scan_en           <= iface_cfg[CFG_SCAN_BIT];
			if (iface_cfg[2]) begin
				o_host_sel <= host_sel_t'({i_iface_sel_pin_b, i_iface_sel_pin_a});
				o_low_voltage_twowire <= {i_iface_sel_pin_b, i_iface_sel_pin_a} == 2'b11;
			end else begin
				o_host_sel <= host_sel_t'(iface_cfg[1:0]);
				o_low_voltage_twowire <= iface_cfg[1:0] == 2'b11;
			end
		end
	end

	// read path: data stand the cycle after the strobe
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			rd_img <= 1'b0;
			rd_reg <= '0;
		end else begin
			rd_img <= i_rd && in_image(i_addr);
			rd_reg <= '0;
			if (i_rd) begin
				unique case (i_addr)
					RA_CMD:       rd_reg <= {3'd0, proto_sel};
					RA_STATUS:    rd_reg <= {5'd0, proto_rx, busy_err, o_ready};
					RA_IFACE_CFG: rd_reg <= iface_cfg & 8'h9F;
					RA_TWI_ADDR:  rd_reg <= {1'b0, o_twi_addr};
					RA_SAM_ADDR:  rd_reg <= {1'b0, o_sam_addr};
					RA_TX_CRC:    rd_reg <= o_transmit_crc_init;
					RA_PROTO_TX:  rd_reg <= REG_TX_BASE;
					RA_PROTO_RX:  rd_reg <= REG_RX_BASE;
					default:      rd_reg <= '0;
				endcase
			end
		end
	end

	assign o_rdata = rd_img ? ram_rdata : rd_reg;
endmodule // eeprom_startup_config_loader
`default_nettype wire

/* bench/cfg_nv_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cfg_nv_model (
	// request side
	input  wire logic        i_mclk,
	input  wire logic        i_rd,
	input  wire logic [12:0] i_addr,
	// answer side
	output logic      [7:0]  o_data
);
	logic [7:0] mem [0:8191];
	initial begin
		for (int i = 0; i < 8192; i++)
			mem[i] = 8'(i) ^ 8'h3C;
		o_data = 8'h00;
	end
	// outside the answer cycle the lines toggle, so stale data never looks valid
	always @(posedge i_mclk)
		o_data <= i_rd ? mem[i_addr] : ~o_data;
endmodule // cfg_nv_model
`default_nettype wire

/* bench/cfg_loader_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module cfg_loader_checker import cfg_loader_pkg::*; (
	input wire logic        i_mclk,
	input wire logic        i_srst,
	input wire logic        o_nv_rd,
	input wire logic [12:0] o_nv_addr,
	input wire logic [7:0]  i_nv_rdata,
	input wire logic [7:0]  i_addr,
	input wire logic [7:0]  i_wdata,
	input wire logic        i_wr,
	input wire logic        o_ready,
	input wire logic [6:0]  o_twi_addr,
	input wire logic [6:0]  o_sam_addr,
	input wire logic [1:0]  o_host_sel,
	input wire logic        o_twi_speed_variant,
	input wire logic        o_scan_en
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_srst);
	logic        got;
	logic [12:0] la;
	logic [7:0]  cfg, twi, sam;
	logic [4:0]  pn;
	always_ff @(posedge i_mclk) begin
		got <= o_nv_rd;
		la <= o_nv_addr;
		if (i_wr)
			pn <= i_wdata[4:0];
	end
	// shadow of the address, interface and module header bytes as they arrive from memory
	always_ff @(posedge i_mclk) begin
		if (got && la == 13'h0020)
			twi <= i_nv_rdata;
		if (got && la == 13'h0021)
			cfg <= i_nv_rdata;
		if (got && la == 13'h0022)
			sam <= i_nv_rdata;
	end
	property p_speed; o_ready |-> o_twi_speed_variant == cfg[7]; endproperty
	a_speed: assert property (p_speed) else $error("speed variant wrong");
	property p_scan; o_ready |-> o_scan_en == cfg[3]; endproperty
	a_scan: assert property (p_scan) else $error("scan enable wrong");
	property p_host; o_ready && !cfg[2] |-> o_host_sel == cfg[1:0]; endproperty
	a_host: assert property (p_host) else $error("host select wrong");
	property p_pin_addr; o_ready && !cfg[4] |-> o_twi_addr[6:2] == 5'h15; endproperty
	a_pin_addr: assert property (p_pin_addr) else $error("pin address wrong");
	property p_nv_addr; o_ready && cfg[4] |-> o_twi_addr == twi[6:0]; endproperty
	a_nv_addr: assert property (p_nv_addr) else $error("stored address wrong");
	property p_sam; o_ready |-> o_sam_addr == sam[6:0]; endproperty
	a_sam: assert property (p_sam) else $error("module address wrong");
	property p_hold;
		o_ready && $past(o_ready) |-> $stable(o_host_sel) && $stable(o_twi_addr);
	endproperty
	a_hold: assert property (p_hold) else $error("choice moved");
	property p_ready; o_nv_rd && o_nv_addr == 13'h009F |-> !o_ready ##[1:8] o_ready; endproperty
	a_ready: assert property (p_ready) else $error("ready timing wrong");
	property p_seq;
		o_nv_rd && $past(o_nv_rd) && o_nv_addr > NV_RESET_IMAGE && o_nv_addr < NV_PROTO_BASE
			|-> o_nv_addr == $past(o_nv_addr) + 13'd1;
	endproperty
	a_seq: assert property (p_seq) else $error("image order wrong");
	property p_load;
		i_wr && i_addr == 8'h00 && i_wdata[7] && o_ready && !o_nv_rd
			|=> ##[0:1] (o_nv_rd && o_nv_addr == 13'h1C00 + 13'(pn) * 13'd24);
	endproperty
	a_load: assert property (p_load) else $error("load start wrong");
	c_ready: cover property ($rose(o_ready));
	c_load: cover property (o_nv_rd && o_nv_addr == 13'h1C30);
	c_stored: cover property (o_ready && cfg[4]);
endmodule // cfg_loader_checker
bind eeprom_startup_config_loader cfg_loader_checker chk_i (.*);
`default_nettype wire

/* bench/eeprom_startup_config_loader_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module eeprom_startup_config_loader_tb;
	import cfg_loader_pkg::*;
	logic        i_mclk, i_srst, pa, pb, pc, nv_rd, i_wr, i_rd, rdy, spd, lv, scan;
	logic [12:0] nv_addr;
	logic [7:0]  nv_data, i_addr, i_wdata, rdata, crc, d;
	logic [6:0]  twi, sam;
	host_sel_t   hs;
	int          fails, n_checks;
	eeprom_startup_config_loader DUT (.i_mclk(i_mclk), .i_srst(i_srst),
		.i_iface_sel_pin_a(pa), .i_iface_sel_pin_b(pb), .i_iface_sel_pin_c(pc),
		.o_nv_rd(nv_rd), .o_nv_addr(nv_addr), .i_nv_rdata(nv_data),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata),
		.o_ready(rdy), .o_twi_addr(twi), .o_sam_addr(sam), .o_host_sel(hs),
		.o_twi_speed_variant(spd), .o_low_voltage_twowire(lv), .o_scan_en(scan),
		.o_transmit_crc_init(crc));
	cfg_nv_model nv (.i_mclk(i_mclk), .i_rd(nv_rd), .i_addr(nv_addr), .o_data(nv_data));
	initial begin
		i_mclk = 1'b0;
		forever #50 i_mclk = ~i_mclk;
	end
	task automatic chk(string nm, logic [7:0] s, logic [7:0] e);
		n_checks++;
		if (s !== e) begin
			fails++;
			$display("wrong value %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] v);
		@(posedge i_mclk);
		i_addr <= a;
		i_wdata <= v;
		i_wr <= 1'b1;
		@(posedge i_mclk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a, output logic [7:0] v);
		@(posedge i_mclk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1 v = rdata;
	endtask
	// pins c and a are kept equal in pin mode, so their order in the address cannot matter
	task automatic boot(logic [7:0] cfg, logic [2:0] p);
		nv.mem[13'h21] = cfg;
		@(posedge i_mclk);
		{pc, pb, pa} <= p;
		i_srst <= 1'b1;
		repeat (2) @(posedge i_mclk);
		i_srst <= 1'b0;
		for (int i = 0; i < 300 && rdy !== 1'b1; i++)
			@(posedge i_mclk);
		#1;
		chk("ready", {7'b0, rdy}, 8'h01);
		chk("speed", {7'b0, spd}, {7'b0, cfg[7]});
		chk("scan", {7'b0, scan}, {7'b0, cfg[3]});
		chk("host", {6'b0, hs}, {6'b0, cfg[2] ? p[1:0] : cfg[1:0]});
		chk("twi", {1'b0, twi}, {1'b0, cfg[4] ? nv.mem[13'h20][6:0] : {5'h15, p[2], p[0]}});
		chk("sam", {1'b0, sam}, {1'b0, nv.mem[13'h22][6:0]});
		chk("crc", crc, nv.mem[NV_TX_CRC_INIT]);
		chk("lv", {7'b0, lv}, {7'b0, (cfg[2] ? p[1:0] : cfg[1:0]) == 2'b11});
		rd(RA_IFACE_CFG, d);
		chk("cfg", d, cfg & 8'h9F);
		rd(RA_IMAGE_BASE, d);
		chk("img_first", d, nv.mem[13'h40]);
		rd(RA_IMAGE_LAST, d);
		chk("img_last", d, nv.mem[13'h9F]);
	endtask
	task automatic t_hold;
		logic [6:0] t;
		host_sel_t  h;
		t = twi;
		h = hs;
		@(posedge i_mclk);
		{pc, pb, pa} <= ~{pc, pb, pa};
		repeat (3) @(posedge i_mclk);
		chk("hold_twi", {1'b0, twi}, {1'b0, t});
		chk("hold_host", {6'b0, hs}, {6'b0, h});
	endtask
	task automatic t_regs;
		wr(8'h41, 8'hA7);
		rd(8'h41, d);
		chk("img_write", d, 8'hA7);
		rd(8'h20, d);
		chk("unmapped", d, 8'h00);
	endtask
	// second command while busy must be refused and flagged
	task automatic t_load(logic [4:0] n);
		logic [12:0] b;
		b = 13'h1C00 + 13'(n) * 13'd24;
		wr(RA_CMD, {3'b100, n});
		wr(RA_CMD, {3'b100, n});
		for (int i = 0; i < 60; i++) begin
			rd(RA_STATUS, d);
			if (d[2] === 1'b0)
				break;
		end
		chk("busy_err", {7'b0, d[1]}, 8'h01);
		wr(RA_STATUS, 8'h02);
		rd(RA_STATUS, d);
		chk("busy_clr", {7'b0, d[1]}, 8'h00);
		for (int i = 0; i < 24; i++) begin
			rd(i < 16 ? 8'(8'h68 + i) : 8'(8'h98 + i - 16), d);
			chk("proto", d, nv.mem[b + 13'(i)]);
		end
	endtask
	task automatic wrap_up;
		if (fails == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#3_000_000;
		fails++;
		wrap_up;
	end
	initial begin
		{i_srst, pa, pb, pc, i_wr, i_rd} = 6'h20;
		i_addr = 8'h00;
		i_wdata = 8'h00;
		fails = 0;
		n_checks = 0;
		boot(8'h88, 3'b000);
		boot(8'h11, 3'b101);
		boot(8'h02, 3'b000);
		boot(8'h9B, 3'b111);
		boot(8'h0C, 3'b111);
		boot(8'h05, 3'b010);
		t_hold;
		t_regs;
		t_load(5'd0);
		t_load(5'd2);
		wrap_up;
	end
endmodule // eeprom_startup_config_loader_tb
`default_nettype wire
